// ---- core/virtual_address_translation_walker.v ----
// Function
// - 31-bit virtual address in, 34-bit physical address out, segments and pages.
// - ring number chooses one of four virtual spaces, which may overlap.
// - a page holds 4096 quarterwords; a space holds up to 2^19 pages.
// - page tables hold 16 entries; their 16 pages form one page group.
// - directory holds one pointer per page table, one continuous list.
// - four lookups: two inside the directory, two to the target.
// - a base register gives the 34-bit start of the descriptor group table.
// - each directory pointer is 8 quarterwords; group table has 16 entries.
// - first index is ring number over virtual-address bits 0 and 1.
// - virtual-address bits 2 to 5 pick the descriptor page entry.
// - virtual-address bits 6 to 14 pick the target group entry.
// - four bits from virtual-address bit 15 pick the target page entry.
// - virtual-address bits 19 to 30 give the quarterword offset in the page.
// - trap when the target page is not resident.
// - record referenced and written status in each target page entry.
// - enforce read, write and execute rights per page.
// - any group or page entry may be null; handle it.
// - no uniqueness check on entry targets.
// - invalid group entry traps group-absent, directory variant for directory.
// - invalid page entry traps page-absent, rest ignored.
// - set used bit on load, modified bit on write.
// - valid page entry gives a 22-bit frame number.
`include "vat_map.vh"
`default_nettype none
module virtual_address_translation_walker (
  input wire mclk, // core clock
  input wire nrst, // async reset, active low
  input wire req, // translation request pulse
  input wire [1:0] req_ring, // ring of the access
  input wire [30:0] req_vaddr, // virtual address, bit 30 is address bit 0
  input wire req_rd, // access reads
  input wire req_wr, // access writes
  input wire req_ex, // access executes
  output reg busy, // walk in progress
  output reg done, // one-cycle pulse, result valid
  output reg [33:0] paddr, // translated physical address
  output reg trap, // one-cycle pulse with done on a trap
  output reg [2:0] trap_code, // cause of the trap
  output reg mem_rd, // memory read pulse
  output reg mem_wr, // memory write pulse
  output reg [33:0] mem_addr, // quarterword address of the entry
  output reg [35:0] mem_wdata, // entry written back
  input wire mem_ack, // memory answer pulse
  input wire [35:0] mem_rdata, // entry read, valid with mem_ack
  input wire [7:0] reg_addr, // register byte address
  input wire [31:0] reg_wdata, // register write data
  input wire reg_wr, // register write strobe
  input wire reg_rd, // register read strobe
  output reg [31:0] reg_rdata // read data, cycle after reg_rd
);
  // ****************************************
  // walk states
  // ****************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ISSUE = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_WB = 3'h3;
  localparam [2:0] S_WBW = 3'h4;
  // lookup order of one walk, directory first, target last
  localparam [1:0] STEP_DGRP = 2'h0;
  localparam [1:0] STEP_DPAGE = 2'h1;
  localparam [1:0] STEP_TGRP = 2'h2;
  localparam [1:0] STEP_TPAGE = 2'h3;

  // ****************************************
  // walk registers
  // ****************************************
  // walk position
  reg [2:0] state_q;
  reg [1:0] step_q;
  // request, held for the whole walk so the core may move on
  reg [1:0] ring_q;
  reg [30:0] va_q;
  reg [2:0] kind_q;
  // descriptor group table base, written by software
  reg [33:0] dir_base_q;
  // base of the table for the next lookup, and target group rights
  reg [33:0] tbl_q;
  reg [2:0] grp_acc_q;
  // outcome of the last walk, kept for software
  reg [2:0] last_trap_q;
  reg [33:0] last_pa_q;

  // ****************************************
  // virtual-address fields
  // ****************************************
  // address bit n sits at req bit 30-n, so bit 0 is the msb
  wire [3:0] idx_dgrp = {ring_q, va_q[30:29]};
  wire [3:0] idx_dpage = va_q[28:25];
  wire [8:0] idx_tgrp = va_q[24:16];
  wire [3:0] idx_tpage = va_q[15:12];
  wire [11:0] pg_off = va_q[11:0];

  // fields of the entry just returned
  wire ent_valid = mem_rdata[`VAT_VALID];
  wire [33:0] ent_pta = {mem_rdata[`VAT_STE_PTA_HI:0], 2'b00};
  wire [2:0] ste_acc = mem_rdata[`VAT_STE_ACC_HI:`VAT_STE_ACC_LO];
  wire [2:0] pte_acc = mem_rdata[`VAT_PTE_ACC_HI:`VAT_PTE_ACC_LO];
  wire [21:0] frame_number = mem_rdata[`VAT_FRAME_HI:0];
  wire [2:0] eff_acc = grp_acc_q & pte_acc;
  // a request asking for any right the page lacks is blocked
  wire acc_bad = |(kind_q & ~eff_acc);

  // ****************************************
  // entry address for each lookup
  // ****************************************
  reg [33:0] ent_addr;
  always @*
  begin
    case (step_q)
      // group entries are 8 quarterwords, page entries 4
      STEP_DGRP: ent_addr = dir_base_q + {27'h0, idx_dgrp, 3'h0};
      STEP_DPAGE: ent_addr = tbl_q + {28'h0, idx_dpage, 2'h0};
      STEP_TGRP: ent_addr = {tbl_q[33:12], idx_tgrp, 3'h0};
      default: ent_addr = tbl_q + {28'h0, idx_tpage, 2'h0};
    endcase
  end

  // ****************************************
  // walk state machine
  // ****************************************
  // four lookups, then an optional write-back of the target page entry;
  // nothing checks whether two entries share a target, so rings may
  // alias the same tables freely
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      // idle, no memory traffic, no result shown
      state_q <= S_IDLE;
      step_q <= STEP_DGRP;
      ring_q <= 2'h0;
      va_q <= 31'h0;
      kind_q <= 3'h0;
      tbl_q <= 34'h0;
      grp_acc_q <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
      trap <= 1'b0;
      trap_code <= `VAT_TRAP_NONE;
      paddr <= 34'h0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 34'h0;
      mem_wdata <= 36'h0;
      last_trap_q <= `VAT_TRAP_NONE;
      last_pa_q <= 34'h0;
    end
    else
    begin
      // every pulse output drops unless a branch raises it
      done <= 1'b0;
      trap <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      case (state_q)
        // latch the request; requests while busy are ignored
        S_IDLE:
        begin
          if (req)
          begin
            ring_q <= req_ring;
            va_q <= req_vaddr;
            kind_q <= {req_wr, req_ex, req_rd};
            step_q <= STEP_DGRP;
            busy <= 1'b1;
            state_q <= S_ISSUE;
          end
        end
        // one lookup per pass; mem_addr stands until the next lookup
        S_ISSUE:
        begin
          mem_rd <= 1'b1;
          mem_addr <= ent_addr;
          state_q <= S_WAIT;
        end
        // memory latency is open, so the walk waits for the answer
        S_WAIT:
        begin
          if (mem_ack)
          begin
            if (!ent_valid)
            begin
              // null entry: stop here, ignore the other fields
              done <= 1'b1;
              trap <= 1'b1;
              busy <= 1'b0;
              state_q <= S_IDLE;
              // directory lookups report their own trap variants
              case (step_q)
                STEP_DGRP: trap_code <= `VAT_TRAP_DIR_GROUP;
                STEP_DPAGE: trap_code <= `VAT_TRAP_DIR_PAGE;
                STEP_TGRP: trap_code <= `VAT_TRAP_GROUP;
                default: trap_code <= `VAT_TRAP_PAGE;
              endcase
              // software sees the same cause in the status register
              case (step_q)
                STEP_DGRP: last_trap_q <= `VAT_TRAP_DIR_GROUP;
                STEP_DPAGE: last_trap_q <= `VAT_TRAP_DIR_PAGE;
                STEP_TGRP: last_trap_q <= `VAT_TRAP_GROUP;
                default: last_trap_q <= `VAT_TRAP_PAGE;
              endcase
            end
            else
            begin
              case (step_q)
                // descriptor page table of this ring and address quarter
                STEP_DGRP:
                begin
                  tbl_q <= ent_pta; // any ring may point here
                  step_q <= STEP_DPAGE;
                  state_q <= S_ISSUE;
                end
                // one page of the directory itself
                STEP_DPAGE:
                begin
                  // directory page frame; low 12 bits index it
                  tbl_q <= {frame_number, 12'h000};
                  step_q <= STEP_TGRP;
                  state_q <= S_ISSUE;
                end
                // target page table and the group's rights
                STEP_TGRP:
                begin
                  tbl_q <= ent_pta;
                  grp_acc_q <= ste_acc;
                  step_q <= STEP_TPAGE;
                  state_q <= S_ISSUE;
                end
                // target page entry: rights, bookkeeping, result
                default:
                begin
                  // kept on paddr even on a rights trap; the PA registers are not updated
                  paddr <= {frame_number, pg_off};
                  // rights are checked before any bookkeeping is written
                  if (acc_bad)
                  begin
                    done <= 1'b1;
                    trap <= 1'b1;
                    trap_code <= `VAT_TRAP_ACCESS;
                    last_trap_q <= `VAT_TRAP_ACCESS;
                    busy <= 1'b0;
                    state_q <= S_IDLE;
                  end
                  else if (!mem_rdata[`VAT_PTE_USED] ||
                           (kind_q[`VAT_ACC_W] && !mem_rdata[`VAT_PTE_MOD]))
                  begin
                    // write back only when a bit changes, saving the write and its answer
                    mem_wdata <= mem_rdata |
                      {1'b0, 1'b1, kind_q[`VAT_ACC_W], 33'h0};
                    state_q <= S_WB;
                  end
                  // bookkeeping already current: finish at once
                  else
                  begin
                    done <= 1'b1;
                    trap_code <= `VAT_TRAP_NONE;
                    last_trap_q <= `VAT_TRAP_NONE;
                    last_pa_q <= {frame_number, pg_off};
                    busy <= 1'b0;
                    state_q <= S_IDLE;
                  end
                end
              endcase
            end
          end
        end
        // bookkeeping write of the target page entry
        S_WB:
        begin
          // same address as the page entry just read
          mem_wr <= 1'b1;
          state_q <= S_WBW;
        end
        // the walk ends only once the write is answered
        S_WBW:
        begin
          if (mem_ack)
          begin
            done <= 1'b1;
            trap_code <= `VAT_TRAP_NONE;
            last_trap_q <= `VAT_TRAP_NONE;
            last_pa_q <= paddr;
            busy <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        // unused state codes fall back to idle
        default:
        begin
          busy <= 1'b0;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // register port
  // ****************************************
  // write decode, one register per strobe
  wire wr_base_lo = reg_wr && (reg_addr == `VAT_BASE_LO);
  wire wr_base_hi = reg_wr && (reg_addr == `VAT_BASE_HI);

  // base writes during a walk take effect at the next walk's first lookup
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      // base stays at zero until software writes it
      dir_base_q <= `VAT_BASE_RST;
      reg_rdata <= 32'h0;
    end
    else
    begin
      if (wr_base_lo)
      begin
        dir_base_q[31:0] <= reg_wdata;
      end
      if (wr_base_hi)
      begin
        dir_base_q[33:32] <= reg_wdata[1:0];
      end
      // read data stand for one cycle only, zero otherwise
      reg_rdata <= 32'h0;
      if (reg_rd)
      begin
        // unmapped offsets read as zero
        case (reg_addr)
          `VAT_BASE_LO: reg_rdata <= dir_base_q[31:0];
          `VAT_BASE_HI: reg_rdata <= {30'h0, dir_base_q[33:32]};
          `VAT_STATUS: reg_rdata <= {28'h0, last_trap_q, busy};
          `VAT_PA_LO: reg_rdata <= last_pa_q[31:0];
          `VAT_PA_HI: reg_rdata <= {30'h0, last_pa_q[33:32]};
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/vat_map.vh ----
`ifndef VAT_MAP_VH
`define VAT_MAP_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define VAT_BASE_LO 8'h00
`define VAT_BASE_HI 8'h04
`define VAT_STATUS 8'h08
`define VAT_PA_LO 8'h0c
`define VAT_PA_HI 8'h10
`define VAT_BASE_RST 34'h000000000
// ****************************************
// table entry fields (36-bit singleword)
// ****************************************
`define VAT_VALID 35
`define VAT_STE_ACC_HI 34
`define VAT_STE_ACC_LO 32
`define VAT_STE_PTA_HI 31
`define VAT_PTE_USED 34
`define VAT_PTE_MOD 33
`define VAT_PTE_ACC_HI 32
`define VAT_PTE_ACC_LO 30
`define VAT_FRAME_HI 21
// access bits inside a 3-bit access field
`define VAT_ACC_W 2
`define VAT_ACC_X 1
`define VAT_ACC_R 0
// ****************************************
// trap codes
// ****************************************
`define VAT_TRAP_NONE 3'h0
`define VAT_TRAP_DIR_GROUP 3'h1
`define VAT_TRAP_GROUP 3'h2
`define VAT_TRAP_DIR_PAGE 3'h3
`define VAT_TRAP_PAGE 3'h4
`define VAT_TRAP_ACCESS 3'h5
`endif

// ---- bench/walker_chk.sv ----
`default_nettype none
module walker_chk (
  input wire logic mclk, // core clock
  input wire logic nrst, // async reset, active low
  input wire logic req, // request pulse
  input wire logic [30:0] req_vaddr, // virtual address
  input wire logic busy, // walk in progress
  input wire logic done, // end of walk
  input wire logic [33:0] paddr, // translated address
  input wire logic trap, // trap pulse
  input wire logic [2:0] trap_code, // trap cause
  input wire logic mem_rd, // memory read pulse
  input wire logic mem_wr, // memory write pulse
  input wire logic [35:0] mem_wdata, // write-back word
  input wire logic reg_rd, // register read strobe
  input wire logic [31:0] reg_rdata // register read data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // helper state and assertions
  // ****************************************
  logic [30:0] va_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // keep the address of the walk in flight, the offset must survive it
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      va_q <= '0;
    else if (req && !busy)
      va_q <= req_vaddr;
  end
  AST_DONE_PULSE: assert property (done |=> !done) else $error("done longer than one cycle");
  AST_TRAP_DONE: assert property (trap |-> done) else $error("trap without done");
  AST_TRAP_CAUSE: assert property (trap |-> trap_code != 3'h0) else $error("trap without cause");
  AST_OK_CODE: assert property (done && !trap |-> trap_code == 3'h0) else $error("code on success");
  AST_START: assert property (req && !busy |=> busy ##1 mem_rd) else $error("walk did not start");
  AST_OFFSET: assert property (done && !trap |-> paddr[11:0] == va_q[11:0])
    else $error("page offset not carried");
  AST_END_IDLE: assert property (done |-> !busy) else $error("busy at done");
  AST_ONE_OP: assert property (!(mem_rd && mem_wr)) else $error("read and write together");
  AST_WB_USED: assert property (mem_wr |-> mem_wdata[35] && mem_wdata[34])
    else $error("write-back without used bit");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  COV_OK: cover property (done && !trap);
  COV_TRAP: cover property (trap);
  COV_WB: cover property (mem_wr);
endmodule
`default_nettype wire

// ---- bench/table_memory.sv ----
`default_nettype none
module table_memory (
  input wire logic mclk, // core clock
  input wire logic mem_rd, // read pulse
  input wire logic mem_wr, // write pulse
  input wire logic [33:0] mem_addr, // entry address
  input wire logic [35:0] mem_wdata, // entry written
  output logic mem_ack, // answer pulse
  output logic [35:0] mem_rdata // entry read
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // table store, absent keys read as invalid
  // ****************************************
  logic [35:0] mem [logic [33:0]];
  int lat = 1;
  int wr_count = 0;
  logic [33:0] a;
  logic w;
  initial
  begin
    mem_ack = 1'b0;
    mem_rdata = '0;
  end
  // one access at a time; data flips after ack so a stale valid word reads as invalid
  initial forever
  begin
    @(posedge mclk);
    if (mem_rd || mem_wr)
    begin
      a = mem_addr;
      w = mem_wr;
      if (w)
        mem[a] = mem_wdata;
      wr_count += w;
      repeat (lat - 1) @(posedge mclk);
      mem_ack <= 1'b1;
      mem_rdata <= w ? ~mem_rdata : (mem.exists(a) ? mem[a] : 36'h0);
      @(posedge mclk);
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- bench/virtual_address_translation_walker_tb.sv ----
`include "vat_map.vh"
`default_nettype none
module virtual_address_translation_walker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, nrst = 0, req = 0, req_rd = 0, req_wr = 0, req_ex = 0;
  logic [1:0] req_ring = '0;
  logic [30:0] req_vaddr = '0;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, rd;
  logic reg_wr = 0, reg_rd = 0, busy, done, trap, mem_rd, mem_wr, mem_ack, got_trap;
  logic [33:0] paddr, mem_addr, got_pa;
  logic [2:0] trap_code, got_code;
  logic [35:0] mem_wdata, mem_rdata;
  logic [30:0] va0 = {2'b01, 4'h3, 9'h0a5, 4'hb, 12'h123};
  int bad_count = 0, cmp_count = 0;
  // ****************************************
  // clock, design and table memory
  // ****************************************
  always #4 mclk = ~mclk;
  virtual_address_translation_walker u_virtual_address_translation_walker (.mclk(mclk),
    .nrst(nrst), .req(req), .req_ring(req_ring), .req_vaddr(req_vaddr), .req_rd(req_rd),
    .req_wr(req_wr), .req_ex(req_ex), .busy(busy), .done(done), .paddr(paddr), .trap(trap),
    .trap_code(trap_code), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  table_memory u_table_memory (.mclk(mclk), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // ****************************************
  // access tasks
  // ****************************************
  function automatic logic [35:0] grp(input logic [2:0] acc, input logic [31:0] sw);
    return {1'b1, acc, sw};
  endfunction
  function automatic logic [35:0] pge(input logic [1:0] um, input logic [2:0] acc,
    input logic [21:0] fr);
    return {1'b1, um, acc, 8'h00, fr};
  endfunction
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  // sample the done cycle at its closing edge, before the design moves on
  task automatic walk(input logic [1:0] ring, input logic [30:0] va, input logic [2:0] wxr);
    int n;
    n = 0;
    @(posedge mclk);
    req <= 1'b1;
    req_ring <= ring;
    req_vaddr <= va;
    {req_wr, req_ex, req_rd} <= wxr;
    @(posedge mclk);
    req <= 1'b0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    chk({35'h0, done}, 36'h1);
    got_trap = trap;
    got_code = trap_code;
    got_pa = paddr;
  endtask
  task automatic trap_case(input logic [1:0] ring, input logic [30:0] va,
    input logic [2:0] wxr, input logic [2:0] code);
    walk(ring, va, wxr);
    chk({got_trap, got_code}, {32'h0, 1'b1, code});
    reg_read(`VAT_STATUS, rd);
    chk(rd, {28'h0, code, 1'b0});
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    reg_read(`VAT_BASE_LO, rd);
    chk(rd, 36'h0);
    reg_write(`VAT_BASE_LO, 32'h1000);
    reg_write(`VAT_BASE_HI, 32'h7);
    reg_read(`VAT_BASE_HI, rd);
    chk(rd, 36'h3);
    reg_write(`VAT_BASE_HI, 32'h0);
    reg_read(`VAT_BASE_LO, rd);
    chk(rd, 36'h1000);
    reg_read(8'h40, rd);
    chk(rd, 36'h0);
    // rings 2 and 1 share one descriptor page table
    u_table_memory.mem[34'h1048] = grp(3'h7, 32'h800);
    u_table_memory.mem[34'h1028] = grp(3'h7, 32'h800);
    u_table_memory.mem[34'h200c] = pge(2'b00, 3'h7, 22'h5);
    u_table_memory.mem[34'h5528] = grp(3'h7, 32'h1800);
    u_table_memory.mem[34'h602c] = pge(2'b00, 3'h7, 22'h2abcd);
    u_table_memory.mem[34'h6030] = pge(2'b00, 3'h5, 22'h1);
    walk(2'd2, va0, 3'b100);
    chk({got_trap, got_pa}, {1'b0, 22'h2abcd, 12'h123});
    chk(u_table_memory.mem[34'h602c], pge(2'b11, 3'h7, 22'h2abcd));
    reg_read(`VAT_PA_LO, rd);
    chk(rd, 36'h2abcd123);
    reg_read(`VAT_PA_HI, rd);
    chk(rd, 36'h0);
    u_table_memory.lat = 3;
    walk(2'd1, va0, 3'b001);
    chk({got_trap, got_pa}, {1'b0, 22'h2abcd, 12'h123});
    chk(36'(u_table_memory.wr_count), 36'h1);
    trap_case(2'd0, va0, 3'b001, 3'h1);
    trap_case(2'd2, {va0[30:29], 4'h4, va0[24:0]}, 3'b001, 3'h3);
    trap_case(2'd2, {va0[30:25], 9'h0a6, va0[15:0]}, 3'b001, 3'h2);
    trap_case(2'd2, {va0[30:16], 4'h2, va0[11:0]}, 3'b001, 3'h4);
    trap_case(2'd2, {va0[30:16], 4'hc, va0[11:0]}, 3'b010, 3'h5);
    end_sim;
  end
  initial
  begin
    #100000;
    bad_count++;
    end_sim;
  end
endmodule
bind virtual_address_translation_walker walker_chk u_walker_chk (.mclk(mclk), .nrst(nrst),
  .req(req), .req_vaddr(req_vaddr), .busy(busy), .done(done), .paddr(paddr), .trap(trap),
  .trap_code(trap_code), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire
